// file: exec_defines.vh
// Purpose: Constants shared by the execution unit for arithmetic, logic and branch groups.
// Assumes: One core clock; decode supplies one operation code per issue.
// Notes: Operation codes are internal to this core; the branch codes and the register and I/O skip codes are decoded as ranges and must stay contiguous.
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH
// ****************************************
// Operation codes
// ****************************************
`define OP_ADD 6'h00
`define OP_ADD_CARRY 6'h01
`define OP_DIFF 6'h02
`define OP_DIFF_REG_IMM 6'h03
`define OP_DIFF_WITH_BORROW 6'h04
`define OP_DIFF_IMM_WITH_BORROW 6'h05
`define OP_CONJ 6'h06
`define OP_BITWISE_CONJ_IMM 6'h07
`define OP_DISJ 6'h08
`define OP_BITWISE_DISJ_IMM 6'h09
`define OP_BITWISE_XOR 6'h0A
`define OP_MASK_CLEAR_BITS 6'h0B
`define OP_ZERO_MINUS_TEST 6'h0C
`define OP_POINTER_JUMP 6'h0D
`define OP_POINTER_CALL 6'h0E
`define OP_EQUAL_COMPARE_SKIP 6'h0F
`define OP_COMPARE 6'h10
`define OP_COMPARE_CARRY 6'h11
`define OP_COMPARE_IMMEDIATE 6'h12
`define OP_SKIP_REG_BIT_LOW 6'h13
`define OP_SKIP_REG_BIT_HIGH 6'h14
`define OP_SKIP_IO_BIT_LOW 6'h15
`define OP_SKIP_IO_BIT_HIGH 6'h16
`define OP_BRANCH_STATUS_BIT_HIGH 6'h17
`define OP_BRANCH_STATUS_BIT_LOW 6'h18
`define OP_BRANCH_SIGNED_GE 6'h19
`define OP_BRANCH_SIGNED_LT 6'h1A
`define OP_BRANCH_UNSIGNED_GE 6'h1B
`define OP_BRANCH_UNSIGNED_LT 6'h1C
`define OP_BRANCH_HALFCARRY_HIGH 6'h1D
`define OP_BRANCH_HALFCARRY_LOW 6'h1E
`define OP_BRANCH_TRANSFER_BIT_HIGH 6'h1F
`define OP_BRANCH_TRANSFER_BIT_LOW 6'h20
`define OP_BRANCH_OVF_HIGH 6'h21
`define OP_BRANCH_OVF_LOW 6'h22
`define OP_BRANCH_CARRY_HIGH 6'h23
`define OP_BRANCH_CARRY_LOW 6'h24
// ****************************************
// Status flag positions
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
// ****************************************
// Clock counts and reset values
// ****************************************
`define CLK_ALU 2'h1
`define CLK_JUMP 2'h2
`define CLK_CALL_SHORT 2'h3
`define CLK_CALL_LONG 2'h0
`define CLK_NOT_TAKEN 2'h1
`define CLK_TAKEN 2'h2
`define CLK_SKIP_TWO 2'h3
`define RST_BYTE 8'h00
`define RST_PC 22'h000000
`define MASK_ALL 8'hFF
`endif

// file: alu_branch_exec.v
// Purpose: Executes arithmetic, logic, compare, skip, branch and pointer jump or call operations.
// Assumes: Operands, status flags and program counter arrive from decode with op_valid.
// Notes: All results are registered; ready falls while a multi-clock operation runs.
`timescale 1ns/1ps
`include "exec_defines.vh"

// Operation
// RL1: Plain add writes sum, ignores carry, sets Z C N V S H, one clock.
// RL2: Add with carry writes sum plus carry, sets six flags, one clock.
// RL3: Register and immediate subtract store difference, set six flags, one clock.
// RL4: Subtract with borrow also removes carry, sets six flags, one clock.
// RL5: AND, OR, XOR store result, set Z N V S, keep C H.
// RL6: Mask clear ANDs with FF minus mask, sets Z N V S, one clock.
// RL7: Zero-or-minus test ANDs register with itself, sets Z N V S.
// RL8: Pointer jump loads PC from Z, upper bits zero, no flags, two clocks.
// RL9: Pointer call loads PC from Z, no flags, three or four clocks.
// RL10: Equal compare skips next instruction on match, no flags, one to three clocks.
// RL11: Compares subtract without storing, set Z N V C S H, one clock.
// RL12: Skip when selected register bit is zero, no flags, one to three clocks.
// RL13: Skip when selected register bit is one, no flags, one to three clocks.
// RL14: Skip when addressed I/O bit is zero, no flags, one to three clocks.
// RL15: Skip when addressed I/O bit is one, no flags, one to three clocks.
// RL16: Status bit branch adds offset plus one when taken; one or two clocks.
// RL17: Signed branches test N xor V for zero or one, one or two clocks.
// RL18: Unsigned branches test carry clear or set, adding offset plus one.
// RL19: Half-carry branches taken on H one or zero, one or two clocks.
// RL20: Transfer-bit branches test T flag, jump by offset plus one.
// RL21: Overflow branches test V set or clear, one or two clocks.
// RL22: Carry branches jump on carry clear or set, altering no flag.
// RL23: Taken skip costs one extra clock, two for a two-word follower.
module alu_branch_exec #(
   parameter LONG_CALL = 0
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Issue from decode
   input wire op_valid,
   input wire [5:0] op,
   input wire [7:0] rd_val,
   input wire [7:0] rr_val,
   input wire [7:0] imm,
   input wire [2:0] bit_sel,
   input wire io_bit,
   input wire [6:0] offset,
   input wire next_two_word,
   input wire [7:0] flags_in,
   input wire [21:0] pc_in,
   input wire [15:0] z_ptr,
   // Status
   output reg ready,
   output reg done,
   // Register file write
   output reg result_we,
   output reg [7:0] result,
   // Status flag write
   output reg flags_we,
   output reg [7:0] flags_out,
   // Program counter and stack
   output reg pc_we,
   output reg [21:0] pc_out,
   output reg push_we,
   output reg [21:0] push_addr
);

// ****************************************
// Operand selection and arithmetic
// ****************************************
reg is_imm;
reg is_add;
reg is_sub;
reg is_logic;
reg use_cin;
reg store;
reg [7:0] b_op;
reg [7:0] res;
reg [8:0] wide;
reg [4:0] low;
reg half;
reg ovf;
reg [7:0] next_flags;

always @* begin
   // One entry per code keeps a renumbered code from silently landing in the wrong group.
   is_imm = 1'b0;
   is_add = 1'b0;
   is_sub = 1'b0;
   is_logic = 1'b0;
   use_cin = 1'b0;
   store = 1'b0;
   case (op)
      `OP_ADD: begin
         is_add = 1'b1;
         store = 1'b1; // RL1
      end
      `OP_ADD_CARRY: begin
         is_add = 1'b1;
         use_cin = 1'b1;
         store = 1'b1; // RL2
      end
      `OP_DIFF: begin
         is_sub = 1'b1;
         store = 1'b1; // RL3
      end
      `OP_DIFF_REG_IMM: begin
         is_sub = 1'b1;
         is_imm = 1'b1;
         store = 1'b1; // RL3
      end
      `OP_DIFF_WITH_BORROW: begin
         is_sub = 1'b1;
         use_cin = 1'b1;
         store = 1'b1; // RL4
      end
      `OP_DIFF_IMM_WITH_BORROW: begin
         is_sub = 1'b1;
         is_imm = 1'b1;
         use_cin = 1'b1;
         store = 1'b1; // RL4
      end
      `OP_CONJ, `OP_DISJ, `OP_BITWISE_XOR, `OP_ZERO_MINUS_TEST: begin
         is_logic = 1'b1;
         store = 1'b1; // RL5 RL7
      end
      `OP_BITWISE_CONJ_IMM, `OP_BITWISE_DISJ_IMM, `OP_MASK_CLEAR_BITS: begin
         is_logic = 1'b1;
         is_imm = 1'b1;
         store = 1'b1; // RL5 RL6
      end
      `OP_COMPARE: begin
         // Compares share the subtractor but never write the register file.
         is_sub = 1'b1; // RL11
      end
      `OP_COMPARE_CARRY: begin
         is_sub = 1'b1;
         use_cin = 1'b1; // RL11
      end
      `OP_COMPARE_IMMEDIATE: begin
         is_sub = 1'b1;
         is_imm = 1'b1; // RL11
      end
      default: begin
         // Branch, skip, pointer and unknown codes leave the arithmetic idle.
         store = 1'b0;
      end
   endcase
   b_op = is_imm ? imm : rr_val;
   wide = 9'h000;
   low = 5'h00;
   res = 8'h00;
   half = 1'b0;
   ovf = 1'b0;
   if (is_add) begin
      // Plain add never looks at the incoming carry.
      wide = {1'b0, rd_val} + {1'b0, b_op} + {8'h00, use_cin & flags_in[`FLAG_C]}; // RL1 RL2
      low = {1'b0, rd_val[3:0]} + {1'b0, b_op[3:0]} + {4'h0, use_cin & flags_in[`FLAG_C]};
      res = wide[7:0];
      half = low[4];
      ovf = (rd_val[7] & b_op[7] & ~res[7]) | (~rd_val[7] & ~b_op[7] & res[7]);
   end else if (is_sub) begin
      wide = {1'b0, rd_val} - {1'b0, b_op} - {8'h00, use_cin & flags_in[`FLAG_C]}; // RL3 RL4 RL11
      low = {1'b0, rd_val[3:0]} - {1'b0, b_op[3:0]} - {4'h0, use_cin & flags_in[`FLAG_C]};
      res = wide[7:0];
      half = low[4];
      ovf = (rd_val[7] & ~b_op[7] & ~res[7]) | (~rd_val[7] & b_op[7] & res[7]);
   end else begin
      case (op)
         `OP_CONJ, `OP_BITWISE_CONJ_IMM: res = rd_val & b_op; // RL5
         `OP_DISJ, `OP_BITWISE_DISJ_IMM: res = rd_val | b_op; // RL5
         `OP_BITWISE_XOR: res = rd_val ^ b_op; // RL5
         `OP_MASK_CLEAR_BITS: res = rd_val & (`MASK_ALL - imm); // RL6
         `OP_ZERO_MINUS_TEST: res = rd_val & rd_val; // RL7
         default: res = 8'h00;
      endcase
   end
   next_flags = flags_in;
   if (is_add || is_sub) begin
      // Carry-using subtract and compare only keep Z when the previous result was zero too.
      next_flags[`FLAG_Z] = (res == 8'h00) & (~(is_sub & use_cin) | flags_in[`FLAG_Z]);
      next_flags[`FLAG_C] = wide[8];
      next_flags[`FLAG_H] = half;
      next_flags[`FLAG_N] = res[7];
      next_flags[`FLAG_V] = ovf;
      next_flags[`FLAG_S] = res[7] ^ ovf; // RL1 RL2 RL3 RL4 RL11
   end else if (is_logic) begin
      next_flags[`FLAG_Z] = (res == 8'h00);
      next_flags[`FLAG_N] = res[7];
      next_flags[`FLAG_V] = 1'b0;
      next_flags[`FLAG_S] = res[7]; // RL5 RL6 RL7
   end
end

// ****************************************
// Branch and skip decisions
// ****************************************
reg is_branch;
reg is_skip;
reg taken;
reg [1:0] clocks;
reg [21:0] next_pc;
reg [21:0] pc_step;

always @* begin
   is_branch = (op >= `OP_BRANCH_STATUS_BIT_HIGH) && (op <= `OP_BRANCH_CARRY_LOW);
   is_skip = (op == `OP_EQUAL_COMPARE_SKIP) || (op >= `OP_SKIP_REG_BIT_LOW && op <= `OP_SKIP_IO_BIT_HIGH);
   case (op)
      `OP_EQUAL_COMPARE_SKIP: taken = (rd_val == rr_val); // RL10
      `OP_SKIP_REG_BIT_LOW: taken = ~rr_val[bit_sel]; // RL12
      `OP_SKIP_REG_BIT_HIGH: taken = rr_val[bit_sel]; // RL13
      `OP_SKIP_IO_BIT_LOW: taken = ~io_bit; // RL14
      `OP_SKIP_IO_BIT_HIGH: taken = io_bit; // RL15
      `OP_BRANCH_STATUS_BIT_HIGH: taken = flags_in[bit_sel]; // RL16
      `OP_BRANCH_STATUS_BIT_LOW: taken = ~flags_in[bit_sel]; // RL16
      `OP_BRANCH_SIGNED_GE: taken = ~(flags_in[`FLAG_N] ^ flags_in[`FLAG_V]); // RL17
      `OP_BRANCH_SIGNED_LT: taken = flags_in[`FLAG_N] ^ flags_in[`FLAG_V]; // RL17
      `OP_BRANCH_UNSIGNED_GE: taken = ~flags_in[`FLAG_C]; // RL18
      `OP_BRANCH_UNSIGNED_LT: taken = flags_in[`FLAG_C]; // RL18
      `OP_BRANCH_HALFCARRY_HIGH: taken = flags_in[`FLAG_H]; // RL19
      `OP_BRANCH_HALFCARRY_LOW: taken = ~flags_in[`FLAG_H]; // RL19
      `OP_BRANCH_TRANSFER_BIT_HIGH: taken = flags_in[`FLAG_T]; // RL20
      `OP_BRANCH_TRANSFER_BIT_LOW: taken = ~flags_in[`FLAG_T]; // RL20
      `OP_BRANCH_OVF_HIGH: taken = flags_in[`FLAG_V]; // RL21
      `OP_BRANCH_OVF_LOW: taken = ~flags_in[`FLAG_V]; // RL21
      `OP_BRANCH_CARRY_HIGH: taken = flags_in[`FLAG_C]; // RL22
      `OP_BRANCH_CARRY_LOW: taken = ~flags_in[`FLAG_C]; // RL22
      default: taken = 1'b0;
   endcase
   // The offset is two's complement, so it is sign-extended to the full counter width.
   pc_step = 22'h000001;
   if (is_branch && taken) begin
      pc_step = {{15{offset[6]}}, offset} + 22'h000001; // RL16 RL18 RL20
   end else if (is_skip && taken) begin
      pc_step = next_two_word ? 22'h000003 : 22'h000002; // RL10
   end
   next_pc = pc_in + pc_step;
   if (op == `OP_POINTER_JUMP || op == `OP_POINTER_CALL) begin
      next_pc = {6'h00, z_ptr}; // RL8 RL9
   end
   if (op == `OP_POINTER_JUMP) begin
      clocks = `CLK_JUMP; // RL8
   end else if (op == `OP_POINTER_CALL) begin
      // A count of zero stands for four clocks in the two-bit counter.
      clocks = (LONG_CALL != 0) ? `CLK_CALL_LONG : `CLK_CALL_SHORT; // RL9
   end else if (is_skip && taken) begin
      clocks = next_two_word ? `CLK_SKIP_TWO : `CLK_TAKEN; // RL23
   end else if (is_branch && taken) begin
      clocks = `CLK_TAKEN; // RL16 RL17 RL19 RL21
   end else begin
      clocks = `CLK_ALU; // RL1 RL3 RL5 RL11
   end
end

// ****************************************
// Issue and clock counting
// ****************************************
reg [1:0] remain;
wire issue;
assign issue = op_valid & ready;

always @(posedge clk or posedge rst) begin
   if (rst) begin
      ready <= 1'b1;
      done <= 1'b0;
      remain <= 2'h0;
      result_we <= 1'b0;
      result <= `RST_BYTE;
      flags_we <= 1'b0;
      flags_out <= `RST_BYTE;
      pc_we <= 1'b0;
      pc_out <= `RST_PC;
      push_we <= 1'b0;
      push_addr <= `RST_PC;
   end else begin
      result_we <= 1'b0;
      flags_we <= 1'b0;
      pc_we <= 1'b0;
      push_we <= 1'b0;
      done <= 1'b0;
      if (issue) begin
         // Results land at the issue edge; the remaining clocks only hold off the next issue.
         result_we <= store;
         result <= res;
         flags_we <= is_add | is_sub | is_logic; // RL8 RL9 RL10 RL22
         flags_out <= next_flags;
         pc_we <= is_branch | is_skip | (op == `OP_POINTER_JUMP) | (op == `OP_POINTER_CALL);
         pc_out <= next_pc;
         push_we <= (op == `OP_POINTER_CALL); // RL9
         push_addr <= pc_in + 22'h000001;
         remain <= clocks - 2'h1;
         ready <= (clocks == `CLK_ALU);
         done <= (clocks == `CLK_ALU);
      end else if (!ready) begin
         // A request offered while ready is low is dropped without a sign, so decode must hold it.
         remain <= remain - 2'h1;
         if (remain == 2'h1) begin
            ready <= 1'b1;
            done <= 1'b1;
         end
      end
   end
end

endmodule

// file: alu_branch_exec_chk.sv
// Purpose: Concurrent checks on the execution unit ports.
// Assumes: Outputs appear one clock after the issue edge.
// Notes: Bound into every instance of the execution unit.
`timescale 1ns/1ps
`include "exec_defines.vh"
module alu_branch_exec_chk #(
   parameter LONG_CALL = 0
) (
   // Clock and reset
   input logic clk,
   input logic rst,
   // Issue
   input logic op_valid,
   input logic [5:0] op,
   input logic [7:0] rd_val,
   input logic [7:0] rr_val,
   input logic [6:0] offset,
   input logic next_two_word,
   input logic [7:0] flags_in,
   input logic [21:0] pc_in,
   input logic [15:0] z_ptr,
   // Results
   input logic ready,
   input logic done,
   input logic result_we,
   input logic [7:0] result,
   input logic flags_we,
   input logic [7:0] flags_out,
   input logic pc_we,
   input logic [21:0] pc_out,
   input logic push_we,
   input logic [21:0] push_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire issue = op_valid && ready;
   // A two-clock operation stalls one cycle and then completes.
   sequence s_stall_then_done;
      !ready ##1 (ready && done);
   endsequence
   a_add_sum: assert property (issue && op == `OP_ADD |=> result_we && result == $past(rd_val) + $past(rr_val))
      else $error("add result wrong");
   a_xor_keeps_ch: assert property (issue && op == `OP_BITWISE_XOR |=> flags_we && flags_out[0] == $past(flags_in[0])
      && flags_out[5] == $past(flags_in[5])) else $error("logic op changed carry or half carry");
   a_compare_no_store: assert property (issue && op == `OP_COMPARE |=> flags_we && !result_we
      && flags_out[1] == ($past(rd_val) == $past(rr_val))) else $error("compare stored or bad zero");
   a_pointer_jump: assert property (issue && op == `OP_POINTER_JUMP |=> pc_we && pc_out == {6'h00, $past(z_ptr)}
      && !flags_we ##0 s_stall_then_done) else $error("pointer jump wrong");
   a_call_three: assert property (issue && op == `OP_POINTER_CALL && LONG_CALL == 0 |=> push_we
      && push_addr == $past(pc_in) + 22'h1 ##0 (!ready && !done)[*2] ##1 (ready && done)) else $error("call wrong");
   a_ge_taken: assert property (issue && op == `OP_BRANCH_SIGNED_GE && !(flags_in[2] ^ flags_in[3]) |=> pc_we
      && pc_out == $past(pc_in) + {{15{$past(offset[6])}}, $past(offset)} + 22'h1 ##0 s_stall_then_done)
      else $error("taken branch wrong");
   a_lt_not_taken: assert property (issue && op == `OP_BRANCH_SIGNED_LT && !(flags_in[2] ^ flags_in[3]) |=> pc_we
      && pc_out == $past(pc_in) + 22'h1 && ready && done && !flags_we) else $error("untaken branch wrong");
   a_skip_two_word: assert property (issue && op == `OP_EQUAL_COMPARE_SKIP && rd_val == rr_val && next_two_word
      |=> pc_out == $past(pc_in) + 22'h3 ##0 (!ready)[*2] ##1 done) else $error("long skip wrong");
endmodule
bind alu_branch_exec alu_branch_exec_chk #(.LONG_CALL(LONG_CALL)) chk (.clk(clk), .rst(rst), .op_valid(op_valid),
   .op(op), .rd_val(rd_val), .rr_val(rr_val), .offset(offset), .next_two_word(next_two_word), .flags_in(flags_in),
   .pc_in(pc_in), .z_ptr(z_ptr), .ready(ready), .done(done), .result_we(result_we), .result(result),
   .flags_we(flags_we), .flags_out(flags_out), .pc_we(pc_we), .pc_out(pc_out), .push_we(push_we),
   .push_addr(push_addr));

// file: alu_and_branch_execution_test.sv
// Purpose: Self-checking bench for the execution unit.
// Assumes: Default three-clock pointer call.
// Notes: Inputs change on the falling edge; outputs are sampled 1 ns after the rising edge.
`timescale 1ns/1ps
`include "exec_defines.vh"
module alu_and_branch_execution_test;
   reg clk = 0, rst = 1, op_valid = 0, io_bit = 0, next_two_word = 0;
   reg [5:0] op = 0;
   reg [7:0] rd_val = 0, rr_val = 0, imm = 0, flags_in = 0, res_s, fl_s;
   reg [2:0] bit_sel = 3'h6;
   reg [6:0] offset = 7'h7E;
   reg [21:0] pc_in = 22'h000100, pc_s, psh_s;
   reg [15:0] z_ptr = 16'hABCD;
   reg rwe_s, fwe_s, pwe_s, hwe_s;
   wire ready, done, result_we, flags_we, pc_we, push_we;
   wire [7:0] result, flags_out;
   wire [21:0] pc_out, push_addr;
   integer n, mismatches = 0, checks_done = 0;
   always #5 clk = ~clk;
   alu_branch_exec dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .rd_val(rd_val), .rr_val(rr_val),
      .imm(imm), .bit_sel(bit_sel), .io_bit(io_bit), .offset(offset), .next_two_word(next_two_word),
      .flags_in(flags_in), .pc_in(pc_in), .z_ptr(z_ptr), .ready(ready), .done(done), .result_we(result_we),
      .result(result), .flags_we(flags_we), .flags_out(flags_out), .pc_we(pc_we), .pc_out(pc_out),
      .push_we(push_we), .push_addr(push_addr));
   task end_sim;
      begin
         $display("checks %0d, mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task ck(input [63:0] name, input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
         end
      end
   endtask
   // Issues one operation and counts edges up to done; a hang is capped at eight edges.
   task go(input [5:0] o);
      reg seen;
      begin
         @(negedge clk);
         op = o;
         op_valid = 1;
         @(posedge clk);
         #1;
         {res_s, fl_s, rwe_s, fwe_s, pwe_s, hwe_s, pc_s, psh_s} =
            {result, flags_out, result_we, flags_we, pc_we, push_we, pc_out, push_addr};
         seen = done;
         n = 1;
         @(negedge clk);
         op_valid = 0;
         while (seen !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n = n + 1;
            seen = done;
         end
         if (n >= 8) begin
            mismatches = mismatches + 1;
            end_sim;
         end
         // Return on a falling edge so that the caller's next operands change away from the sampling edge.
         @(negedge clk);
      end
   endtask
   task alu(input [5:0] o, input [7:0] a, b, k, fin, r, f, input we);
      begin
         rd_val = a;
         rr_val = b;
         imm = k;
         flags_in = fin;
         go(o);
         if (we)
            ck("result", res_s, r);
         ck("res_we", rwe_s, we);
         ck("flags", fl_s, f);
         ck("flg_we", fwe_s, 1);
         ck("clocks", n, 1);
      end
   endtask
   task br(input [5:0] o, input [7:0] fin, input tk);
      begin
         flags_in = fin;
         go(o);
         ck("pc", pc_s, tk ? 22'h0000FF : 22'h000101);
         ck("pc_we", pwe_s, 1);
         ck("flg_we", fwe_s, 0);
         ck("clocks", n, tk ? 2 : 1);
      end
   endtask
   task sk(input [5:0] o, input [7:0] a, b, input iob, tw, tk);
      begin
         rd_val = a;
         rr_val = b;
         io_bit = iob;
         next_two_word = tw;
         bit_sel = 3'h7;
         go(o);
         ck("pc", pc_s, tk ? (tw ? 22'h000103 : 22'h000102) : 22'h000101);
         ck("flg_we", fwe_s, 0);
         ck("clocks", n, tk ? (tw ? 3 : 2) : 1);
      end
   endtask
   task t_pointer;
      begin
         pc_in = 22'h3F0000;
         go(`OP_POINTER_JUMP);
         ck("pc", pc_s, 22'h00ABCD);
         ck("clocks", n, 2);
         go(`OP_POINTER_CALL);
         ck("pc", pc_s, 22'h00ABCD);
         ck("push", psh_s, 22'h3F0001);
         ck("push_we", hwe_s, 1);
         ck("flg_we", fwe_s, 0);
         ck("clocks", n, 3);
         pc_in = 22'h000100;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 0;
      alu(`OP_ADD, 8'h8F, 8'h71, 8'h00, 8'h00, 8'h00, 8'h23, 1);
      alu(`OP_ADD_CARRY, 8'h7F, 8'h00, 8'h00, 8'h01, 8'h80, 8'h2C, 1);
      alu(`OP_DIFF, 8'h10, 8'h01, 8'h00, 8'h00, 8'h0F, 8'h20, 1);
      alu(`OP_DIFF_REG_IMM, 8'h00, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h35, 1);
      alu(`OP_DIFF_WITH_BORROW, 8'h80, 8'h00, 8'h00, 8'h01, 8'h7F, 8'h38, 1);
      alu(`OP_DIFF_IMM_WITH_BORROW, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h02, 1);
      alu(`OP_BITWISE_XOR, 8'hA5, 8'hA5, 8'h00, 8'h21, 8'h00, 8'h23, 1);
      alu(`OP_BITWISE_CONJ_IMM, 8'hF0, 8'h00, 8'h8F, 8'h08, 8'h80, 8'h14, 1);
      alu(`OP_CONJ, 8'h0F, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h02, 1);
      alu(`OP_DISJ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 1);
      alu(`OP_BITWISE_DISJ_IMM, 8'h01, 8'h00, 8'h80, 8'h00, 8'h81, 8'h14, 1);
      alu(`OP_MASK_CLEAR_BITS, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'hF0, 8'h14, 1);
      alu(`OP_ZERO_MINUS_TEST, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80, 8'h14, 1);
      alu(`OP_COMPARE, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h02, 0);
      alu(`OP_COMPARE_CARRY, 8'h05, 8'h05, 8'h00, 8'h01, 8'h00, 8'h35, 0);
      alu(`OP_COMPARE_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h35, 0);
      t_pointer;
      br(`OP_BRANCH_STATUS_BIT_HIGH, 8'h40, 1);
      br(`OP_BRANCH_STATUS_BIT_HIGH, 8'h00, 0);
      br(`OP_BRANCH_STATUS_BIT_LOW, 8'h00, 1);
      br(`OP_BRANCH_SIGNED_GE, 8'h0C, 1);
      br(`OP_BRANCH_SIGNED_GE, 8'h04, 0);
      br(`OP_BRANCH_SIGNED_LT, 8'h08, 1);
      br(`OP_BRANCH_SIGNED_LT, 8'h00, 0);
      br(`OP_BRANCH_UNSIGNED_GE, 8'h01, 0);
      br(`OP_BRANCH_UNSIGNED_LT, 8'h01, 1);
      br(`OP_BRANCH_HALFCARRY_HIGH, 8'h20, 1);
      br(`OP_BRANCH_HALFCARRY_LOW, 8'h20, 0);
      br(`OP_BRANCH_TRANSFER_BIT_HIGH, 8'h40, 1);
      br(`OP_BRANCH_TRANSFER_BIT_LOW, 8'h40, 0);
      br(`OP_BRANCH_OVF_HIGH, 8'h08, 1);
      br(`OP_BRANCH_OVF_LOW, 8'h00, 1);
      br(`OP_BRANCH_CARRY_HIGH, 8'h01, 1);
      br(`OP_BRANCH_CARRY_LOW, 8'h01, 0);
      sk(`OP_EQUAL_COMPARE_SKIP, 8'h5A, 8'h5A, 0, 1, 1);
      sk(`OP_EQUAL_COMPARE_SKIP, 8'h5A, 8'h5B, 0, 0, 0);
      sk(`OP_SKIP_REG_BIT_LOW, 8'h00, 8'h7F, 0, 0, 1);
      sk(`OP_SKIP_REG_BIT_HIGH, 8'h00, 8'h80, 0, 1, 1);
      sk(`OP_SKIP_IO_BIT_LOW, 8'h00, 8'h00, 1, 0, 0);
      sk(`OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h00, 1, 0, 1);
      end_sim;
   end
endmodule
